/* File: include/fws_pkg.sv */
/*
  package for the flash write/status host controller: command codes, unlock
  addresses, status bit positions, bus cycle timing counts and carrier types.
  assumes a 100 MHz system clock and a word-wide (x16) parallel flash bus.
*/
package fws_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  // bus cycle phase lengths in nanoseconds, as chosen for a comfortable strobe
  localparam int unsigned SETUP_NS = 30;
  localparam int unsigned STROBE_NS = 50;
  localparam int unsigned HOLD_NS = 30;
  // least times round up to whole cycles
  localparam int unsigned SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOLD_CYC = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TIMER_W = 4;

  localparam int unsigned ADDR_W = 20;
  localparam int unsigned DATA_W = 16;

  // unlock addresses (word mode)
  localparam logic [19:0] UNLOCK_ADDR1 = 20'h00555;
  localparam logic [19:0] UNLOCK_ADDR2 = 20'h002aa;
  localparam logic [19:0] DONT_CARE_ADDR = 20'h00000;
  // sector select field: address bits 19 down to 12
  localparam int unsigned SECTOR_MSB = 19;
  localparam int unsigned SECTOR_LSB = 12;
  localparam logic [19:0] PROTECT_VERIFY_OFS = 20'h00002;

  // command bytes
  localparam logic [15:0] CMD_UNLOCK1 = 16'h00aa;
  localparam logic [15:0] CMD_UNLOCK2 = 16'h0055;
  localparam logic [15:0] CMD_AUTOSELECT = 16'h0090;
  localparam logic [15:0] CMD_PROGRAM = 16'h00a0;
  localparam logic [15:0] CMD_BYPASS = 16'h0020;
  localparam logic [15:0] CMD_BYPASS_EXIT = 16'h0000;
  localparam logic [15:0] CMD_ERASE_SETUP = 16'h0080;
  localparam logic [15:0] CMD_SECTOR_ERASE = 16'h0030;
  localparam logic [15:0] CMD_CHIP_ERASE = 16'h0010;
  localparam logic [15:0] CMD_SUSPEND = 16'h00b0;
  localparam logic [15:0] CMD_RESUME = 16'h0030;
  localparam logic [15:0] CMD_RESET = 16'h00f0;

  // status bit positions on the data bus
  localparam int unsigned POLL_BIT = 7;
  localparam int unsigned TOGGLE_ONE_BIT = 6;
  localparam int unsigned TIMEOUT_BIT = 5;
  localparam int unsigned ERASE_WINDOW_BIT = 3;
  localparam int unsigned TOGGLE_TWO_BIT = 2;
  localparam logic [15:0] PROTECTED_CODE = 16'h0001;

  // user operations
  typedef enum logic [3:0] {
    FWS_OP_READ, FWS_OP_RESET, FWS_OP_PROGRAM, FWS_OP_BYPASS_ENTER,
    FWS_OP_BYPASS_PROGRAM, FWS_OP_BYPASS_EXIT, FWS_OP_SECTOR_ERASE,
    FWS_OP_CHIP_ERASE, FWS_OP_SUSPEND, FWS_OP_RESUME, FWS_OP_PROTECT_CHECK,
    FWS_OP_STATUS
  } fws_op_t;

  // outcome codes of an operation
  typedef enum logic [1:0] {
    FWS_RES_OK, FWS_RES_FAIL, FWS_RES_BUSY
  } fws_res_t;

  // one bus cycle as handed to the cycle engine
  typedef struct packed {
    logic write;
    logic [19:0] addr;
    logic [15:0] data;
  } fws_cycle_t;

  // decoded status word
  typedef struct packed {
    logic poll;
    logic toggle_one;
    logic timeout;
    logic erase_window;
    logic toggle_two;
  } fws_status_t;
endpackage : fws_pkg

/* File: rtl/fws_bus_cycle.sv */
/*
  one strobe-timed bus cycle on the flash pins: setup, strobe low, hold.
  assumes the caller holds start high for one cycle only while ready_out is high.
*/
`timescale 1ns/1ps
module fws_bus_cycle
  import fws_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire fws_cycle_t cyc_in,
  input wire logic [15:0] dq_in,
  output logic ready_out,
  output logic done_out,
  output logic [15:0] rdata_out,
  output logic [19:0] addr_out,
  output logic [15:0] dq_out,
  output logic dq_oe_out,
  output logic chip_select_n_out,
  output logic write_strobe_n_out,
  output logic output_enable_n_out
);
  typedef enum logic [1:0] {FWS_BC_IDLE, FWS_BC_SETUP, FWS_BC_STROBE, FWS_BC_HOLD} fws_bc_state_t;
  localparam logic [3:0] SETUP_LAST = 4'(SETUP_CYC - 1);
  localparam logic [3:0] STROBE_LAST = 4'(STROBE_CYC - 1);
  localparam logic [3:0] HOLD_LAST = 4'(HOLD_CYC - 1);

  fws_bc_state_t state_q;
  logic [TIMER_W-1:0] timer_q;
  logic write_q;
  logic [15:0] wdata_q;
  wire logic phase_end = (state_q == FWS_BC_SETUP && timer_q == SETUP_LAST) ||
                         (state_q == FWS_BC_STROBE && timer_q == STROBE_LAST) ||
                         (state_q == FWS_BC_HOLD && timer_q == HOLD_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // pin drive: chip select opens first and closes last, so the write strobe
  // edges are the later fall and the earlier rise; address latches on the
  // write strobe fall and data on its rise
  assign ready_out = (state_q == FWS_BC_IDLE);
  assign write_strobe_n_out = !(state_q == FWS_BC_STROBE && write_q);
  assign output_enable_n_out = !(state_q == FWS_BC_STROBE && !write_q);
  assign dq_out = wdata_q;
  assign dq_oe_out = write_q && state_q != FWS_BC_IDLE;

  // phase sequencer
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= FWS_BC_IDLE;
      timer_q <= '0;
      write_q <= 1'b0;
      wdata_q <= '0;
      addr_out <= '0;
      rdata_out <= '0;
      done_out <= 1'b0;
      chip_select_n_out <= 1'b1;
    end else begin
      done_out <= 1'b0;
      timer_q <= phase_end ? '0 : timer_q + 1'b1;
      case (state_q)
        FWS_BC_IDLE: begin
          timer_q <= '0;
          if (start_in) begin
            state_q <= FWS_BC_SETUP;
            write_q <= cyc_in.write;
            wdata_q <= cyc_in.data;
            addr_out <= cyc_in.addr;
            chip_select_n_out <= 1'b0;
          end
        end
        FWS_BC_SETUP: if (phase_end) state_q <= FWS_BC_STROBE;
        FWS_BC_STROBE: begin
          if (phase_end) begin
            state_q <= FWS_BC_HOLD;
            if (!write_q) rdata_out <= dq_in; // sampled before the strobe rises
          end
        end
        FWS_BC_HOLD: begin
          if (phase_end) begin
            state_q <= FWS_BC_IDLE;
            chip_select_n_out <= 1'b1;
            write_q <= 1'b0;
            done_out <= 1'b1;
          end
        end
        default: state_q <= FWS_BC_IDLE;
      endcase
    end
  end

  // write strobe never opens unless chip select is already low
  strobe_framed_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !write_strobe_n_out |-> !chip_select_n_out && $past(!chip_select_n_out))
    else $error("write strobe not framed by chip select");
  data_held_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(write_strobe_n_out) |-> dq_oe_out && $stable(dq_out))
    else $error("write data not held across strobe rise");
endmodule : fws_bus_cycle

/* File: rtl/fws_host.sv */
/*
  host controller for a parallel nor flash: runs command sequences (program,
  unlock bypass, erase, suspend/resume, protect check, reset after autoselect or failure; a reset request writes aa to 555) and polls write
  status until done or failed.
  assumes a word-wide bus, inputs synchronous to clk_in, and an external
  pull-up on the open-drain ready/busy wire.
*/
// Operation
// - command cycles are all write cycles
// - reset command after autoselect or timeout
// - autoselect fourth cycle is a read
// - bypass entry precedes bypass program
// - bypass reset leaves bypass mode
// - read data only after poll shows true
`timescale 1ns/1ps
module fws_host
  import fws_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic req_valid_in,
  input wire fws_op_t req_op_in,
  input wire logic [19:0] req_addr_in,
  input wire logic [15:0] req_data_in,
  output logic req_ready_out,
  output logic resp_valid_out,
  output fws_res_t resp_result_out,
  output logic [15:0] resp_data_out,
  output logic bypass_mode_out,
  output logic suspended_out,
  output fws_status_t status_out,
  input wire logic ready_busy_n_in,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic dq_oe_out,
  output logic [19:0] addr_out,
  output logic chip_select_n_out,
  output logic write_strobe_n_out,
  output logic output_enable_n_out
);
  typedef enum logic [2:0] {FWS_IDLE, FWS_ISSUE, FWS_WAIT, FWS_POLL1, FWS_POLL2, FWS_RECHECK, FWS_FINISH} fws_state_t;

  fws_state_t state_q;
  fws_op_t op_q;
  logic [19:0] addr_q;
  logic [15:0] data_q;
  logic [2:0] step_q;
  logic [15:0] first_q;
  logic failed_q;
  fws_res_t result_q;
  logic [15:0] rdata;
  logic cyc_done;
  logic cyc_ready;
  logic start;
  fws_cycle_t cyc;

  ////////////////////////////////////////////////////////////////////////////
  // build one sequence step; upper address bits are don't care, so the
  // plain unlock addresses are used except on the carrying cycle
  function automatic fws_cycle_t fws_wr(input logic [19:0] a, input logic [15:0] d);
    fws_cycle_t c;
    c.write = 1'b1;
    c.addr = a;
    c.data = d;
    return c;
  endfunction : fws_wr

  // address of a whole sector, only bits 19..12 kept
  function automatic logic [19:0] fws_sector(input logic [19:0] a);
    return {a[SECTOR_MSB:SECTOR_LSB], 12'h000};
  endfunction : fws_sector

  wire logic [2:0] prefix_len = (op_q == FWS_OP_SECTOR_ERASE || op_q == FWS_OP_CHIP_ERASE) ? 3'd6 :
                               (op_q == FWS_OP_PROGRAM || op_q == FWS_OP_PROTECT_CHECK) ? 3'd4 :
                               (op_q == FWS_OP_BYPASS_ENTER) ? 3'd3 :
                               (op_q == FWS_OP_BYPASS_PROGRAM || op_q == FWS_OP_BYPASS_EXIT) ? 3'd2 : 3'd1;
  wire logic [19:0] sector_addr = fws_sector(addr_q);
  // polling address: program location, or a location inside the erased sector
  wire logic [19:0] poll_addr = (op_q == FWS_OP_SECTOR_ERASE) ? sector_addr : addr_q;
  wire logic polls = op_q inside {FWS_OP_PROGRAM, FWS_OP_BYPASS_PROGRAM, FWS_OP_SECTOR_ERASE,
                                  FWS_OP_CHIP_ERASE, FWS_OP_STATUS};

  // step selection for each operation
  always_comb begin
    cyc = fws_wr(DONT_CARE_ADDR, CMD_RESET);
    case (op_q)
      FWS_OP_READ: cyc = '{write: 1'b0, addr: addr_q, data: 16'h0000};
      FWS_OP_STATUS: cyc = '{write: 1'b0, addr: addr_q, data: 16'h0000};
      FWS_OP_SUSPEND: cyc = fws_wr(DONT_CARE_ADDR, CMD_SUSPEND);
      FWS_OP_RESUME: cyc = fws_wr(DONT_CARE_ADDR, CMD_RESUME);
      FWS_OP_BYPASS_PROGRAM: cyc = (step_q == 3'd0) ? fws_wr(DONT_CARE_ADDR, CMD_PROGRAM)
                                   : fws_wr(addr_q, data_q);
      FWS_OP_BYPASS_EXIT: cyc = (step_q == 3'd0) ? fws_wr(DONT_CARE_ADDR, CMD_AUTOSELECT)
                                : fws_wr(DONT_CARE_ADDR, CMD_BYPASS_EXIT);
      default: begin
        case (step_q)
          3'd0: cyc = fws_wr(UNLOCK_ADDR1, CMD_UNLOCK1);
          3'd1: cyc = fws_wr(UNLOCK_ADDR2, CMD_UNLOCK2);
          3'd2: cyc = fws_wr(UNLOCK_ADDR1, op_q == FWS_OP_PROGRAM ? CMD_PROGRAM :
                             op_q == FWS_OP_BYPASS_ENTER ? CMD_BYPASS :
                             op_q == FWS_OP_PROTECT_CHECK ? CMD_AUTOSELECT : CMD_ERASE_SETUP);
          3'd3: begin
            if (op_q == FWS_OP_PROGRAM) begin
              cyc = fws_wr(addr_q, data_q);
            end else if (op_q == FWS_OP_PROTECT_CHECK) begin
              cyc = '{write: 1'b0, addr: sector_addr | PROTECT_VERIFY_OFS, data: 16'h0000};
            end else begin
              cyc = fws_wr(UNLOCK_ADDR1, CMD_UNLOCK1);
            end
          end
          3'd4: cyc = fws_wr(UNLOCK_ADDR2, CMD_UNLOCK2);
          default: cyc = (op_q == FWS_OP_SECTOR_ERASE) ? fws_wr(sector_addr, CMD_SECTOR_ERASE)
                         : fws_wr(UNLOCK_ADDR1, CMD_CHIP_ERASE);
        endcase
      end
    endcase
    if (state_q == FWS_POLL1 || state_q == FWS_POLL2 || state_q == FWS_RECHECK) begin
      cyc = '{write: 1'b0, addr: poll_addr, data: 16'h0000};
    end else if (state_q == FWS_FINISH) begin
      cyc = fws_wr(DONT_CARE_ADDR, CMD_RESET);
    end
  end

  // the engine is idle again in the done cycle; launching there would add a stray bus cycle
  assign start = cyc_ready && !cyc_done &&
                 (state_q inside {FWS_ISSUE, FWS_POLL1, FWS_POLL2, FWS_RECHECK, FWS_FINISH});
  assign req_ready_out = (state_q == FWS_IDLE);

  // status decode of the latest read: toggles compare two successive reads
  wire logic toggle_one = rdata[TOGGLE_ONE_BIT] != first_q[TOGGLE_ONE_BIT];
  wire logic toggle_two = rdata[TOGGLE_TWO_BIT] != first_q[TOGGLE_TWO_BIT];
  wire logic timed_out = rdata[TIMEOUT_BIT];
  // operation over once toggling stops; a protected target also stops after a
  // short busy period, so the poll bit then tells whether the word landed
  wire logic poll_true = (op_q == FWS_OP_PROGRAM || op_q == FWS_OP_BYPASS_PROGRAM) ?
                         (rdata[POLL_BIT] == data_q[POLL_BIT]) : rdata[POLL_BIT];
  wire logic settled = !toggle_one;
  wire logic landed = poll_true || op_q == FWS_OP_STATUS;

  ////////////////////////////////////////////////////////////////////////////
  // sequence controller; busy pin low means the embedded operation still runs
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= FWS_IDLE;
      op_q <= FWS_OP_READ;
      addr_q <= '0;
      data_q <= '0;
      step_q <= '0;
      first_q <= '0;
      failed_q <= 1'b0;
      result_q <= FWS_RES_OK;
      resp_valid_out <= 1'b0;
      resp_result_out <= FWS_RES_OK;
      resp_data_out <= '0;
      bypass_mode_out <= 1'b0;
      suspended_out <= 1'b0;
      status_out <= '0;
    end else begin
      resp_valid_out <= 1'b0;
      case (state_q)
        FWS_IDLE: begin
          if (req_valid_in) begin
            op_q <= req_op_in;
            addr_q <= req_addr_in;
            data_q <= req_data_in;
            step_q <= '0;
            failed_q <= 1'b0;
            result_q <= FWS_RES_OK;
            state_q <= FWS_ISSUE;
          end
        end
        FWS_ISSUE: if (start) state_q <= FWS_WAIT;
        FWS_WAIT: begin
          if (cyc_done) begin
            if (step_q != prefix_len - 3'd1) begin
              step_q <= step_q + 3'd1;
              state_q <= FWS_ISSUE;
            end else if (polls && ready_busy_n_in == 1'b0 || polls && op_q != FWS_OP_STATUS) begin
              state_q <= FWS_POLL1;
            end else begin
              if (op_q == FWS_OP_PROTECT_CHECK) begin
                resp_data_out <= rdata & PROTECTED_CODE;
                state_q <= FWS_FINISH;
              end else begin
                resp_data_out <= rdata;
                resp_result_out <= FWS_RES_OK;
                state_q <= FWS_IDLE;
                resp_valid_out <= 1'b1;
              end
              if (op_q == FWS_OP_BYPASS_ENTER) bypass_mode_out <= 1'b1;
              if (op_q == FWS_OP_BYPASS_EXIT) bypass_mode_out <= 1'b0;
              if (op_q == FWS_OP_SUSPEND) suspended_out <= 1'b1;
              if (op_q == FWS_OP_RESUME) suspended_out <= 1'b0;
            end
          end
        end
        FWS_POLL1: if (cyc_done) begin
          first_q <= rdata;
          state_q <= FWS_POLL2;
        end
        FWS_POLL2, FWS_RECHECK: if (cyc_done) begin
          status_out <= '{poll: rdata[POLL_BIT], toggle_one: toggle_one, timeout: timed_out,
                          erase_window: rdata[ERASE_WINDOW_BIT], toggle_two: toggle_two};
          first_q <= rdata;
          if (settled && !landed) begin
            // toggling stopped but the word never showed: report failure after a reset
            failed_q <= 1'b1;
            state_q <= FWS_FINISH;
          end else if (settled) begin
            // poll bit now true: the data of this read is valid and is returned
            result_q <= failed_q ? FWS_RES_FAIL : FWS_RES_OK;
            resp_data_out <= rdata;
            state_q <= FWS_IDLE;
            resp_valid_out <= 1'b1;
            resp_result_out <= failed_q ? FWS_RES_FAIL : FWS_RES_OK;
          end else if (state_q == FWS_RECHECK || (timed_out && !failed_q)) begin
            // still toggling after timeout: recheck once, then reset
            failed_q <= (state_q == FWS_RECHECK);
            state_q <= (state_q == FWS_RECHECK) ? FWS_FINISH : FWS_RECHECK;
          end else if (op_q == FWS_OP_STATUS) begin
            resp_data_out <= rdata;
            resp_result_out <= FWS_RES_BUSY;
            resp_valid_out <= 1'b1;
            state_q <= FWS_IDLE;
          end else begin
            state_q <= FWS_POLL2;
          end
        end
        FWS_FINISH: if (cyc_done) begin
          state_q <= FWS_IDLE;
          resp_valid_out <= 1'b1;
          resp_result_out <= failed_q ? FWS_RES_FAIL : result_q;
          bypass_mode_out <= 1'b0;
        end
        default: state_q <= FWS_IDLE;
      endcase
    end
  end

  fws_bus_cycle u_cycle (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .start_in(start),
    .cyc_in(cyc),
    .dq_in(dq_in),
    .ready_out(cyc_ready),
    .done_out(cyc_done),
    .rdata_out(rdata),
    .addr_out(addr_out),
    .dq_out(dq_out),
    .dq_oe_out(dq_oe_out),
    .chip_select_n_out(chip_select_n_out),
    .write_strobe_n_out(write_strobe_n_out),
    .output_enable_n_out(output_enable_n_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  sector_addr_a: assert property (@(posedge clk_in) disable iff (rst_in)
    start && cyc.write && cyc.data == CMD_SECTOR_ERASE && op_q == FWS_OP_SECTOR_ERASE
    |-> cyc.addr[11:0] == 12'h000) else $error("sector erase address not sector aligned");
  poll_reads_a: assert property (@(posedge clk_in) disable iff (rst_in)
    start && state_q inside {FWS_POLL1, FWS_POLL2} |-> !cyc.write && cyc.addr == poll_addr)
    else $error("status poll not a read at poll address");
  reset_after_fail_a: assert property (@(posedge clk_in) disable iff (rst_in)
    resp_valid_out && resp_result_out == FWS_RES_FAIL |-> $past(state_q) == FWS_FINISH)
    else $error("failure answered without reset command");
  one_toggle_read_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(state_q == FWS_POLL2) |-> $past(state_q) == FWS_POLL1)
    else $error("toggle compare without a first read");
  autoselect_read_a: assert property (@(posedge clk_in) disable iff (rst_in)
    start && op_q == FWS_OP_PROTECT_CHECK && step_q == 3'd3 && state_q == FWS_ISSUE |-> !cyc.write)
    else $error("autoselect fourth cycle not a read");
  protect_code_a: assert property (@(posedge clk_in) disable iff (rst_in)
    $past(op_q == FWS_OP_PROTECT_CHECK && state_q == FWS_WAIT && cyc_done && step_q == 3'd3)
    |-> resp_data_out[15:1] == 15'h0000) else $error("protect code out of range");
  bypass_order_a: assert property (@(posedge clk_in) disable iff (rst_in)
    resp_valid_out && $past(op_q) == FWS_OP_BYPASS_ENTER && $past(state_q) == FWS_WAIT |-> bypass_mode_out)
    else $error("bypass mode not recorded");
  resume_clears_a: assert property (@(posedge clk_in) disable iff (rst_in)
    resp_valid_out && op_q == FWS_OP_RESUME |-> !suspended_out)
    else $error("suspend flag kept after resume");
endmodule : fws_host

/* File: tb/fws_flash_model.sv */
/*
  behavioural flash device for the host bench: command decoder, timed embedded
  program and sector erase, status bits on framed reads, open-drain busy sink.
  assumes word-mode unlock addresses and a pull-up on the busy wire in the bench.
*/
`timescale 1ns/1ps
module fws_flash_model #(
  parameter int PROG_NS = 600,
  parameter int ERASE_NS = 3000,
  parameter logic [7:0] PROT_SECTOR = 8'h05
) (
  input wire logic [19:0] addr_in,
  input wire logic [15:0] dq_in,
  input wire logic chip_select_n_in,
  input wire logic write_strobe_n_in,
  input wire logic output_enable_n_in,
  output logic [15:0] dq_out,
  output logic busy_pull_out
);
  logic [15:0] mem [logic [19:0]];
  logic [19:0] la;
  logic [15:0] pd;
  logic [7:0] esec;
  int step = 0;
  int op = 0; // 0 array, 1 program, 2 erase, 4 autoselect
  bit bypass = 0, susp = 0, t1 = 0, t2 = 0;
  time end_t = 0, rem = 0;
  function automatic bit busy();
    return (op == 1 || op == 2) && !susp && $time < end_t;
  endfunction : busy
  ////////////////////////////////////////////////////////////////////////////
  initial dq_out = 16'h0000;
  initial busy_pull_out = 1'b0;
  // chip select falls first, so the strobe fall is the later one
  always @(negedge write_strobe_n_in) if (!chip_select_n_in) la = addr_in;
  // decode at the earlier rising strobe; unlock addresses compare only the low 11 bits
  always @(posedge write_strobe_n_in) if (!chip_select_n_in) begin
    if ((op == 1 || op == 2) && !susp && $time >= end_t) op = 0;
    if (dq_in[7:0] == 8'hf0 && !busy()) begin
      op = 0;
      step = 0;
    end else if (busy() && op == 2 && dq_in[7:0] == 8'hb0) begin
      susp = 1;
      rem = end_t - $time;
    end else if (susp && step == 0 && dq_in[7:0] == 8'h30) begin
      susp = 0;
      end_t = $time + rem;
    end else if (!busy()) case (step)
      0: step = (dq_in[7:0] == 8'haa && la[10:0] == 11'h555) ? 1 : (bypass && dq_in[7:0] == 8'ha0) ? 3 :
           (bypass && dq_in[7:0] == 8'h90) ? 7 : 0;
      1, 5: step = (dq_in[7:0] == 8'h55 && la[10:0] == 11'h2aa) ? step + 1 : 0;
      2: begin
        op = (dq_in[7:0] == 8'h90) ? 4 : op;
        bypass = bypass | (dq_in[7:0] == 8'h20);
        step = (dq_in[7:0] == 8'ha0) ? 3 : (dq_in[7:0] == 8'h80) ? 4 : 0;
      end
      3: begin
        // a protected target only shows status for a while, nothing is written
        pd = dq_in;
        op = 1;
        end_t = $time + ((la[19:12] == PROT_SECTOR) ? 2000 : PROG_NS);
        if (la[19:12] != PROT_SECTOR) mem[la] = (mem.exists(la) ? mem[la] : 16'hffff) & dq_in;
        step = 0;
      end
      4: step = (dq_in[7:0] == 8'haa && la[10:0] == 11'h555) ? 5 : 0;
      6: begin
        if (dq_in[7:0] == 8'h30) begin
          esec = la[19:12];
          op = 2;
          end_t = $time + ((esec == PROT_SECTOR) ? 100000 : ERASE_NS);
          foreach (mem[k]) if (k[19:12] == esec && esec != PROT_SECTOR) mem[k] = 16'hffff;
        end
        step = 0;
      end
      7: begin
        bypass = bypass & (dq_in[7:0] != 8'h00);
        step = 0;
      end
      default: step = 0;
    endcase
  end
  // status only on reads framed by chip select and output enable
  always @(negedge output_enable_n_in) if (!chip_select_n_in) begin
    if ((op == 1 || op == 2) && !susp && $time >= end_t) op = 0;
    t1 ^= busy();
    t2 ^= (op == 2 && addr_in[19:12] == esec);
    if (op == 1 || op == 2) dq_out = {8'h00, (op == 1) ? ~pd[7] : susp, t1, 2'b00, op == 2, t2, 2'b00};
    else if (op == 4) dq_out = {15'h0000, addr_in[19:12] == PROT_SECTOR};
    else dq_out = mem.exists(addr_in) ? mem[addr_in] : 16'hffff;
  end
  // a released bus shows the inverse, so a late sample cannot match by luck
  always @(posedge output_enable_n_in) dq_out = ~dq_out;
  always #5 busy_pull_out = busy();
endmodule : fws_flash_model

/* File: tb/fws_host_bench.sv */
/*
  self-checking bench for the flash host: user requests against a reference
  word store, with the device model on the flash pins.
  assumes the pull-up on the busy wire is modelled here.
*/
`timescale 1ns/1ps
module fws_host_bench;
  import fws_pkg::*;
  logic clk_in = 0, rst_in = 1, req_valid_in = 0;
  fws_op_t req_op_in = FWS_OP_READ;
  logic [19:0] req_addr_in = '0, addr_out, a;
  logic [15:0] req_data_in = '0, resp_data_out, dq_out, fl_dq, d;
  logic req_ready_out, resp_valid_out, bypass_mode_out, suspended_out, dq_oe_out, cs_n, we_n, oe_n, pull;
  fws_res_t resp_result_out;
  fws_status_t status_out;
  int num_errors = 0, num_checks = 0;
  logic [15:0] ref_mem [logic [19:0]];
  wire logic ready_busy_n = pull ? 1'b0 : 1'b1; // pull-up unless the device sinks it
  wire logic [15:0] dq_bus = dq_oe_out ? dq_out : fl_dq;
  ////////////////////////////////////////////////////////////////////////////
  fws_host fws_host_inst(.clk_in(clk_in), .rst_in(rst_in), .req_valid_in(req_valid_in), .req_op_in(req_op_in),
    .req_addr_in(req_addr_in), .req_data_in(req_data_in), .req_ready_out(req_ready_out),
    .resp_valid_out(resp_valid_out), .resp_result_out(resp_result_out), .resp_data_out(resp_data_out),
    .bypass_mode_out(bypass_mode_out), .suspended_out(suspended_out), .status_out(status_out),
    .ready_busy_n_in(ready_busy_n), .dq_in(dq_bus), .dq_out(dq_out), .dq_oe_out(dq_oe_out), .addr_out(addr_out),
    .chip_select_n_out(cs_n), .write_strobe_n_out(we_n), .output_enable_n_out(oe_n));
  fws_flash_model #(.PROG_NS(600), .ERASE_NS(3000), .PROT_SECTOR(8'h05)) fws_flash_model_inst(.addr_in(addr_out),
    .dq_in(dq_bus), .chip_select_n_in(cs_n), .write_strobe_n_in(we_n), .output_enable_n_in(oe_n),
    .dq_out(fl_dq), .busy_pull_out(pull));
  initial forever #5 clk_in = ~clk_in;
  task automatic wrap_up();
    if (num_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    num_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask : check
  // one request at a falling edge, then a bounded wait for its answer
  task automatic run_op(input fws_op_t op, input logic [19:0] ad, input logic [15:0] da);
    int n;
    n = 0;
    @(negedge clk_in);
    while (req_ready_out !== 1'b1 && n < 100) begin @(negedge clk_in); n++; end
    if (n == 100) begin num_errors++; wrap_up(); end
    req_op_in = op;
    req_addr_in = ad;
    req_data_in = da;
    req_valid_in = 1;
    @(negedge clk_in);
    req_valid_in = 0;
    n = 0;
    while (resp_valid_out !== 1'b1 && n < 20000) begin @(posedge clk_in); #1; n++; end
    if (n == 20000) begin num_errors++; wrap_up(); end
  endtask : run_op
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hba00));
    repeat (12) @(negedge clk_in);
    rst_in = 0;
    // plain then bypass programming of random words at distinct locations,
    // since a zero bit cannot be programmed back to one
    for (int i = 0; i < 6; i++) begin
      if (i == 3) run_op(FWS_OP_BYPASS_ENTER, 20'h00000, 16'h0000);
      a = {8'h03, 4'h0, 5'(i), 3'($urandom % 8)};
      d = 16'($urandom);
      run_op(i < 3 ? FWS_OP_PROGRAM : FWS_OP_BYPASS_PROGRAM, a, d);
      ref_mem[a] = (ref_mem.exists(a) ? ref_mem[a] : 16'hffff) & d;
      check({14'h0, resp_result_out}, {14'h0, FWS_RES_OK});
      check({15'h0, status_out.poll}, {15'h0, ref_mem[a][7]});
      check({15'h0, bypass_mode_out}, {15'h0, i >= 3});
    end
    run_op(FWS_OP_BYPASS_EXIT, 20'h00000, 16'h0000);
    check({15'h0, bypass_mode_out}, 16'h0000);
    foreach (ref_mem[k]) begin
      run_op(FWS_OP_READ, k, 16'h0000);
      check(resp_data_out, ref_mem[k]);
    end
    // a protected target stays erased
    run_op(FWS_OP_PROGRAM, 20'h05010, 16'h1234);
    check({14'h0, resp_result_out}, {14'h0, FWS_RES_FAIL});
    run_op(FWS_OP_READ, 20'h05010, 16'h0000);
    check(resp_data_out, 16'hffff);
    run_op(FWS_OP_PROTECT_CHECK, 20'h03000, 16'h0000);
    check(resp_data_out, 16'h0000);
    run_op(FWS_OP_PROTECT_CHECK, 20'h05000, 16'h0000);
    check(resp_data_out, 16'h0001);
    run_op(FWS_OP_SECTOR_ERASE, 20'h03000, 16'h0000);
    check({14'h0, resp_result_out}, {14'h0, FWS_RES_OK});
    foreach (ref_mem[k]) begin
      run_op(FWS_OP_READ, k, 16'h0000);
      check(resp_data_out, 16'hffff);
    end
    run_op(FWS_OP_SUSPEND, 20'h00000, 16'h0000);
    check({15'h0, suspended_out}, 16'h0001);
    run_op(FWS_OP_RESUME, 20'h00000, 16'h0000);
    check({15'h0, suspended_out}, 16'h0000);
    wrap_up();
  end
endmodule : fws_host_bench
